/* hdl/color_palette_lookup.sv */
// Colour palette block: APB register port, command FIFO, lookup pipeline
`timescale 1ns/10ps

// ============================================================================
// Command FIFO
module palette_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 32
) (
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);

  localparam int AW = $clog2(DEPTH);

  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH)
      $error("palette_fifo: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;

  assign inReady  = (count_q != (AW+1)'(DEPTH));
  assign outValid = (count_q != '0);
  assign outData  = mem[rdPtr_q];
  assign push     = inValid && inReady;
  assign pop      = outValid && outReady;

  always_ff @(posedge clock)
  begin
    if (push)
      mem[wrPtr_q] <= inData;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push)
        wrPtr_q <= wrPtr_q + AW'(1);
      if (pop)
        rdPtr_q <= rdPtr_q + AW'(1);
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule

// ============================================================================
// Palette top
module color_palette_lookup #(
  parameter int FIFO_DEPTH = palette_pkg::FIFO_DEPTH
) (
  input  wire logic                clock,
  input  wire logic                srst,
  input  wire logic [11:0]         paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire palette_pkg::pixel_s pixelIn,
  input  wire logic                converterShutdown,
  input  wire logic                hsyncIn,
  input  wire logic                vsyncIn,
  output palette_pkg::rgb_s        colorOut,
  output logic                     converterPowerOn,
  output logic                     hsyncOut,
  output logic                     hsyncOe,
  output logic                     vsyncOut,
  output logic                     vsyncOe
);

  function automatic palette_pkg::phase_e nextPhase(input palette_pkg::phase_e ph);
    unique case (ph)
      palette_pkg::PH_RED:   nextPhase = palette_pkg::PH_GREEN;
      palette_pkg::PH_GREEN: nextPhase = palette_pkg::PH_BLUE;
      palette_pkg::PH_BLUE:  nextPhase = palette_pkg::PH_RED;
      default:               nextPhase = palette_pkg::PH_RED;
    endcase
  endfunction

  function automatic logic [5:0] pickComp(input palette_pkg::phase_e ph,
                                          input palette_pkg::rgb_s   c);
    unique case (ph)
      palette_pkg::PH_RED:   pickComp = c.red;
      palette_pkg::PH_GREEN: pickComp = c.green;
      palette_pkg::PH_BLUE:  pickComp = c.blue;
      default:               pickComp = c.red;
    endcase
  endfunction

  // ==========================================================================
  // Storage and software state
  palette_pkg::rgb_s    lut [palette_pkg::ENTRIES];
  logic [7:0]           pixelMask_q;
  palette_pkg::rgb_s    borderColor_q;
  logic [2:0]           control_q;
  logic [7:0]           index_q;
  palette_pkg::phase_e  phase_q;
  logic                 readMode_q;
  palette_pkg::rgb_s    hold_q;
  logic                 powerDown;
  logic                 panelOnly;

  assign powerDown = control_q[palette_pkg::CTL_MONITOR_OFF]
                  && control_q[palette_pkg::CTL_TEXT_MODE];
  assign panelOnly = control_q[palette_pkg::CTL_PANEL_ONLY];

  // ==========================================================================
  // APB slave
  logic              access;
  logic              mapped;
  logic              isPalettePort;
  logic              isColorRead;
  logic              canGo;
  logic              go;
  logic              fifoInReady;
  logic              fifoOutValid;
  logic              fifoPop;
  palette_pkg::cmd_s fifoIn;
  palette_pkg::cmd_s fifoOut;
  logic              fifoPush;
  logic [31:0]       readValue;

  assign access = psel && penable && !pready;
  assign mapped = (paddr == palette_pkg::OFS_PIXEL_MASK)
               || (paddr == palette_pkg::OFS_WRITE_INDEX)
               || (paddr == palette_pkg::OFS_COLOR_DATA)
               || (paddr == palette_pkg::OFS_READ_INDEX)
               || (paddr == palette_pkg::OFS_BORDER_COLOR)
               || (paddr == palette_pkg::OFS_CONTROL)
               || (paddr == palette_pkg::OFS_STATUS);
  assign isPalettePort = (paddr == palette_pkg::OFS_WRITE_INDEX)
                      || (paddr == palette_pkg::OFS_COLOR_DATA)
                      || (paddr == palette_pkg::OFS_READ_INDEX);
  assign isColorRead = !pwrite && (paddr == palette_pkg::OFS_COLOR_DATA);

  // Palette writes queue behind the FIFO; palette reads wait until it drains
  // so a read never overtakes an earlier write.
  assign canGo    = !isPalettePort || (pwrite ? fifoInReady : !fifoOutValid);
  assign go       = access && canGo;
  assign fifoPush = go && mapped && pwrite && isPalettePort;
  assign fifoIn   = '{kind: (paddr == palette_pkg::OFS_WRITE_INDEX) ? palette_pkg::CMD_WIDX :
                            (paddr == palette_pkg::OFS_READ_INDEX)  ? palette_pkg::CMD_RIDX :
                                                                      palette_pkg::CMD_DATA,
                      data: pwdata[7:0]};

  always_comb
  begin
    readValue = 32'h0000_0000;
    if (paddr == palette_pkg::OFS_PIXEL_MASK)
      readValue[7:0] = pixelMask_q;
    else if (paddr == palette_pkg::OFS_WRITE_INDEX || paddr == palette_pkg::OFS_READ_INDEX)
      readValue[7:0] = index_q;
    else if (paddr == palette_pkg::OFS_COLOR_DATA)
      readValue[5:0] = pickComp(phase_q, hold_q);
    else if (paddr == palette_pkg::OFS_BORDER_COLOR)
      readValue[17:0] = borderColor_q;
    else if (paddr == palette_pkg::OFS_CONTROL)
      readValue[2:0] = control_q;
    else if (paddr == palette_pkg::OFS_STATUS)
    begin
      readValue[palette_pkg::STS_PHASE_LSB +: 3] = phase_q;
      readValue[palette_pkg::STS_READ_MODE]      = readMode_q;
      readValue[palette_pkg::STS_POWER_DOWN]     = powerDown;
      readValue[palette_pkg::STS_FIFO_EMPTY]     = !fifoOutValid;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= go;
      pslverr <= go && !mapped;
      if (go && !pwrite)
        prdata <= readValue;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pixelMask_q   <= palette_pkg::MASK_RESET;
      borderColor_q <= palette_pkg::BORDER_RESET;
      control_q     <= palette_pkg::CONTROL_RESET;
    end
    else if (go && pwrite)
    begin
      if (paddr == palette_pkg::OFS_PIXEL_MASK)
        pixelMask_q <= pwdata[7:0];
      if (paddr == palette_pkg::OFS_BORDER_COLOR)
        borderColor_q <= pwdata[17:0];
      if (paddr == palette_pkg::OFS_CONTROL)
        control_q <= pwdata[2:0];
    end
  end

  palette_fifo #(
    .WIDTH ($bits(palette_pkg::cmd_s)),
    .DEPTH (FIFO_DEPTH)
  ) cmdFifo (
    .clock    (clock),
    .srst     (srst),
    .inData   (fifoIn),
    .inValid  (fifoPush),
    .inReady  (fifoInReady),
    .outData  (fifoOut),
    .outValid (fifoOutValid),
    .outReady (fifoPop)
  );

  // ==========================================================================
  // Palette port sequencer
  // Table updates are held off while a visible pixel is being looked up, to
  // keep writes out of the active picture; a short counter bounds the wait
  // so a display that never blanks cannot starve the host.
  palette_pkg::pixel_s pix0_q;
  logic [2:0]          stall_q;
  logic                tableBusy;
  logic                hostColorRead;

  assign tableBusy     = !pix0_q.blank && !powerDown && (stall_q < 3'(palette_pkg::STALL_MAX));
  assign fifoPop       = fifoOutValid && !tableBusy;
  assign hostColorRead = go && isColorRead;

  always_ff @(posedge clock)
  begin
    if (srst || fifoPop || !fifoOutValid)
      stall_q <= 3'h0;
    else
      stall_q <= stall_q + 3'h1;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      index_q    <= 8'h00;
      phase_q    <= palette_pkg::PH_RED;
      readMode_q <= 1'b0;
      hold_q     <= '0;
    end
    else if (fifoPop)
    begin
      unique case (fifoOut.kind)
        palette_pkg::CMD_WIDX:
        begin
          index_q    <= fifoOut.data;
          phase_q    <= palette_pkg::PH_RED;
          readMode_q <= 1'b0;
        end
        palette_pkg::CMD_RIDX:
        begin
          hold_q     <= lut[fifoOut.data];
          index_q    <= fifoOut.data + 8'h01;
          phase_q    <= palette_pkg::PH_RED;
          readMode_q <= 1'b1;
        end
        default:
        begin
          unique case (phase_q)
            palette_pkg::PH_RED:   hold_q.red   <= fifoOut.data[5:0];
            palette_pkg::PH_GREEN: hold_q.green <= fifoOut.data[5:0];
            default:               hold_q.blue  <= fifoOut.data[5:0];
          endcase
          if (phase_q == palette_pkg::PH_BLUE)
            index_q <= index_q + 8'h01;
          phase_q    <= nextPhase(phase_q);
          readMode_q <= 1'b0;
        end
      endcase
    end
    else if (hostColorRead)
    begin
      phase_q <= nextPhase(phase_q);
      if (phase_q == palette_pkg::PH_BLUE)
      begin
        hold_q  <= lut[index_q];
        index_q <= index_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (fifoPop && fifoOut.kind == palette_pkg::CMD_DATA && phase_q == palette_pkg::PH_BLUE)
      lut[index_q] <= '{red: hold_q.red, green: hold_q.green, blue: fifoOut.data[5:0]};
  end

  // ==========================================================================
  // Display pipeline: input register, lookup, select, output
  logic              shut0_q;
  logic              shut1_q;
  logic              blank1_q;
  logic              border1_q;
  palette_pkg::rgb_s look1_q;
  palette_pkg::rgb_s col2_q;
  logic              off2;

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      pix0_q    <= '{index: 8'h00, blank: 1'b1, border: 1'b0};
      shut0_q   <= 1'b1;
      shut1_q   <= 1'b1;
      blank1_q  <= 1'b1;
      border1_q <= 1'b0;
      look1_q   <= '0;
    end
    else
    begin
      pix0_q    <= pixelIn;
      shut0_q   <= converterShutdown;
      shut1_q   <= shut0_q;
      blank1_q  <= pix0_q.blank;
      border1_q <= pix0_q.border;
      look1_q   <= lut[pix0_q.index & pixelMask_q];
    end
  end

  // Powered-down converters give zero; the table still serves the host.
  assign off2 = shut1_q || powerDown || panelOnly;

  always_ff @(posedge clock)
  begin
    if (srst)
      col2_q <= '0;
    else if (off2 || blank1_q)
      col2_q <= '0;
    else if (border1_q)
      col2_q <= borderColor_q;
    else
      col2_q <= look1_q;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      colorOut <= '0;
    else
      colorOut <= col2_q;
  end

  // ==========================================================================
  // Converter power and sync drive
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      converterPowerOn <= 1'b0;
      hsyncOut         <= 1'b0;
      vsyncOut         <= 1'b0;
      hsyncOe          <= 1'b0;
      vsyncOe          <= 1'b0;
    end
    else
    begin
      converterPowerOn <= !(converterShutdown || powerDown || panelOnly);
      hsyncOut         <= hsyncIn;
      vsyncOut         <= vsyncIn;
      hsyncOe          <= !panelOnly;
      vsyncOe          <= !panelOnly;
    end
  end

endmodule

/* hdl/palette_pkg.sv */
// Constants, types and register map of the colour palette block
// Functional notes
// - Table holds 256 entries of eighteen bits.
// - Pixel index picks an entry split into 6-bit red, green, blue.
// - Software pixel mask alters each index before lookup, effective immediately.
// - Host reaches the table through an 8-bit port, independent of pixel timing; here port commands wait on visible pixels for up to STALL_MAX cycles.
// - Pixel, blank, border registered, then reach outputs three edges later.
// - Blank drives zero codes into the converters.
// - Border feeds the border colour register instead of the table.
// - Converter shutdown holds all three outputs at zero.
// - Completed blue byte stores the entry, then index increments.
// - Read index write fetches that entry into data register, increments index.
// - Three reads give red, green, blue; then prefetch and increment again.
// - New start index abandons partial triple and restarts at red.
// - Monitor off plus text mode powers down converters and table, host access stays.
// - Panel-only operation cuts converter power and stops sync drive.
package palette_pkg;

  // ==========================================================================
  // Geometry
  localparam int ENTRIES     = 256;
  localparam int INDEX_W     = 8;
  localparam int COMP_W      = 6;
  localparam int FIFO_DEPTH  = 32;
  localparam int STALL_MAX   = 4;

  // ==========================================================================
  // Register byte offsets
  localparam logic [11:0] OFS_PIXEL_MASK   = 12'h000;
  localparam logic [11:0] OFS_WRITE_INDEX  = 12'h004;
  localparam logic [11:0] OFS_COLOR_DATA   = 12'h008;
  localparam logic [11:0] OFS_READ_INDEX   = 12'h00C;
  localparam logic [11:0] OFS_BORDER_COLOR = 12'h010;
  localparam logic [11:0] OFS_CONTROL      = 12'h014;
  localparam logic [11:0] OFS_STATUS       = 12'h018;

  // Control fields
  localparam int CTL_MONITOR_OFF = 0;
  localparam int CTL_TEXT_MODE   = 1;
  localparam int CTL_PANEL_ONLY  = 2;

  // Status fields
  localparam int STS_PHASE_LSB   = 0;
  localparam int STS_READ_MODE   = 3;
  localparam int STS_POWER_DOWN  = 4;
  localparam int STS_FIFO_EMPTY  = 5;

  // Reset values
  localparam logic [7:0]  MASK_RESET    = 8'hFF;
  localparam logic [17:0] BORDER_RESET  = 18'h00000;
  localparam logic [2:0]  CONTROL_RESET = 3'h0;

  // Host port commands carried through the FIFO
  localparam logic [1:0] CMD_WIDX = 2'h0;
  localparam logic [1:0] CMD_RIDX = 2'h1;
  localparam logic [1:0] CMD_DATA = 2'h2;

  typedef enum logic [2:0] {
    PH_RED   = 3'b001,
    PH_GREEN = 3'b010,
    PH_BLUE  = 3'b100
  } phase_e;

  typedef struct packed {
    logic [INDEX_W-1:0] index;
    logic               blank;
    logic               border;
  } pixel_s;

  typedef struct packed {
    logic [COMP_W-1:0] red;
    logic [COMP_W-1:0] green;
    logic [COMP_W-1:0] blue;
  } rgb_s;

  typedef struct packed {
    logic [1:0] kind;
    logic [7:0] data;
  } cmd_s;

endpackage

/* tb/color_palette_lookup_checker.sv */
// Port-level assertions for the colour palette block
`timescale 1ns/10ps

// ==========================================================================
// Checker
module color_palette_lookup_checker #(
  parameter int FIFO_DEPTH = 32
) (
  input wire logic                clock,
  input wire logic                srst,
  input wire logic [11:0]         paddr,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [31:0]         pwdata,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire palette_pkg::pixel_s pixelIn,
  input wire logic                converterShutdown,
  input wire logic                hsyncIn,
  input wire logic                vsyncIn,
  input wire palette_pkg::rgb_s   colorOut,
  input wire logic                converterPowerOn,
  input wire logic                hsyncOut,
  input wire logic                hsyncOe,
  input wire logic                vsyncOut,
  input wire logic                vsyncOe
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence access_phase;
    psel && penable;
  endsequence

  // Latched at one edge, visible three edges later
  sequence pipe_zero;
    ##4 (colorOut == 18'h00000);
  endsequence

  ready_in_access_a: assert property (pready |-> access_phase)
    else $error("pready outside access phase");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  error_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  read_data_hold_a: assert property (!$stable(prdata) |-> pready && !pwrite)
    else $error("prdata changed outside a read");
  blank_zero_a: assert property (pixelIn.blank |-> pipe_zero)
    else $error("blank pixel gave colour");
  shutdown_zero_a: assert property (converterShutdown |-> pipe_zero)
    else $error("shutdown gave colour");
  reset_blank_a: assert property ($fell(srst) |-> (colorOut == 18'h00000) [*3])
    else $error("colour too early after reset");
  sync_delay_a: assert property (!$past(srst) |->
    hsyncOut == $past(hsyncIn) && vsyncOut == $past(vsyncIn))
    else $error("sync copy not one cycle");
  sync_oe_pair_a: assert property (hsyncOe == vsyncOe && (hsyncOe || !converterPowerOn))
    else $error("sync enables disagree or converters on without sync drive");
endmodule

bind color_palette_lookup color_palette_lookup_checker #(.FIFO_DEPTH(FIFO_DEPTH)) chk_u (
  .clock(clock), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .pixelIn(pixelIn), .converterShutdown(converterShutdown),
  .hsyncIn(hsyncIn), .vsyncIn(vsyncIn), .colorOut(colorOut),
  .converterPowerOn(converterPowerOn), .hsyncOut(hsyncOut), .hsyncOe(hsyncOe),
  .vsyncOut(vsyncOut), .vsyncOe(vsyncOe));

/* tb/color_palette_lookup_test.sv */
// Self-checking testbench for the colour palette block
`timescale 1ns/10ps

// ==========================================================================
// Testbench
module color_palette_lookup_test;
  logic                clock             = 1'b0;
  logic                srst              = 1'b1;
  logic [11:0]         paddr;
  logic                psel;
  logic                penable;
  logic                pwrite;
  logic [31:0]         pwdata;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  palette_pkg::pixel_s pixelIn           = '{index: 8'h00, blank: 1'b1, border: 1'b0};
  logic                converterShutdown = 1'b0;
  logic                hsyncIn           = 1'b0;
  logic                vsyncIn           = 1'b0;
  palette_pkg::rgb_s   colorOut;
  logic                converterPowerOn;
  logic                hsyncOut;
  logic                hsyncOe;
  logic                vsyncOut;
  logic                vsyncOe;
  logic [31:0]         rd;
  logic                er;
  int                  errors            = 0;
  int                  samples_checked   = 0;
  palette_pkg::rgb_s   ent [4]           = '{18'h01083, 18'h3F015, 18'h2A462, 18'h15A9C};

  always #4 clock = ~clock;

  always @(posedge clock)
  begin
    hsyncIn <= ~hsyncIn;
    vsyncIn <= hsyncIn & ~vsyncIn;
  end

  color_palette_lookup dut_u (.clock(clock), .srst(srst), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pixelIn(pixelIn), .converterShutdown(converterShutdown),
    .hsyncIn(hsyncIn), .vsyncIn(vsyncIn), .colorOut(colorOut),
    .converterPowerOn(converterPowerOn), .hsyncOut(hsyncOut), .hsyncOe(hsyncOe),
    .vsyncOut(vsyncOut), .vsyncOe(vsyncOe));

  palette_host_model host_u (.clock(clock), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // ==========================================================================
  // Shared helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: %s got %0h expected %0h", $time, msg, got, exp);
    end
  endtask

  task automatic rdv(input logic [11:0] a, input logic [31:0] exp, input string msg);
    host_u.xfer(1'b0, a, 32'h0, rd, er);
    chk(rd, exp, msg);
  endtask

  // Only six bits of a colour byte carry the component
  task automatic rde(input palette_pkg::rgb_s c, input string msg);
    logic [17:0] got;
    for (int j = 0; j < 3; j++)
    begin
      host_u.xfer(1'b0, palette_pkg::OFS_COLOR_DATA, 32'h0, rd, er);
      got[17-6*j -: 6] = rd[5:0];
    end
    chk({14'h0, got}, {14'h0, c}, msg);
  endtask

  // Holds the pixel long enough that the pipe and any drain stall have settled
  task automatic pix(input logic [7:0] i, input logic b, input logic bd, input logic sh,
                     input logic [17:0] exp, input string msg);
    pixelIn           <= '{index: i, blank: b, border: bd};
    converterShutdown <= sh;
    repeat (8) @(posedge clock);
    chk({14'h0, colorOut}, {14'h0, exp}, msg);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic test_reset();
    rdv(palette_pkg::OFS_PIXEL_MASK, 32'hFF, "mask reset");
    rdv(palette_pkg::OFS_BORDER_COLOR, 32'h0, "border reset");
    rdv(palette_pkg::OFS_CONTROL, 32'h0, "control reset");
    rdv(12'h01C, 32'h0, "unmapped read");
    chk({31'h0, er}, 32'h1, "unmapped error");
    $display("test reset done");
  endtask

  task automatic test_table();
    host_u.load(8'hFE, ent[0], 1'b1);
    host_u.load(8'h00, ent[1], 1'b0);
    host_u.load(8'h00, ent[2], 1'b0);
    host_u.xfer(1'b1, palette_pkg::OFS_READ_INDEX, 32'hFE, rd, er);
    for (int k = 0; k < 3; k++)
      rde(ent[k], "table read");
    rdv(palette_pkg::OFS_READ_INDEX, 32'h02, "index after reads");
    $display("test table done");
  endtask

  task automatic test_restart();
    host_u.xfer(1'b1, palette_pkg::OFS_WRITE_INDEX, 32'h20, rd, er);
    host_u.xfer(1'b1, palette_pkg::OFS_COLOR_DATA, 32'h3F, rd, er);
    host_u.xfer(1'b1, palette_pkg::OFS_COLOR_DATA, 32'h3F, rd, er);
    host_u.load(8'h30, ent[3], 1'b1);
    rdv(palette_pkg::OFS_WRITE_INDEX, 32'h31, "index after restart");
    host_u.xfer(1'b1, palette_pkg::OFS_READ_INDEX, 32'h30, rd, er);
    host_u.xfer(1'b0, palette_pkg::OFS_COLOR_DATA, 32'h0, rd, er);
    chk({26'h0, rd[5:0]}, {26'h0, ent[3].red}, "write restart red");
    host_u.xfer(1'b1, palette_pkg::OFS_READ_INDEX, 32'hFF, rd, er);
    rde(ent[1], "read restart");
    rde(ent[2], "read after wrap");
    $display("test restart done");
  endtask

  task automatic test_display();
    host_u.load(8'h01, ent[2], 1'b1);
    host_u.load(8'h05, ent[3], 1'b1);
    host_u.xfer(1'b1, palette_pkg::OFS_BORDER_COLOR, 32'h2A3C5, rd, er);
    rdv(palette_pkg::OFS_BORDER_COLOR, 32'h2A3C5, "border readback");
    pix(8'h05, 1'b0, 1'b0, 1'b0, ent[3], "lookup");
    pixelIn <= '{index: 8'h01, blank: 1'b0, border: 1'b0};
    repeat (3) @(posedge clock);
    @(negedge clock);
    chk({14'h0, colorOut}, {14'h0, ent[3]}, "output too early");
    @(negedge clock);
    chk({14'h0, colorOut}, {14'h0, ent[2]}, "output latency");
    @(posedge clock);
    host_u.xfer(1'b1, palette_pkg::OFS_PIXEL_MASK, 32'h03, rd, er);
    pix(8'h05, 1'b0, 1'b0, 1'b0, ent[2], "masked lookup");
    host_u.xfer(1'b1, palette_pkg::OFS_PIXEL_MASK, 32'hFF, rd, er);
    pix(8'h05, 1'b0, 1'b1, 1'b0, 18'h2A3C5, "border");
    pix(8'h05, 1'b1, 1'b1, 1'b0, 18'h0, "blank");
    pix(8'h05, 1'b0, 1'b0, 1'b1, 18'h0, "shutdown");
    chk({31'h0, converterPowerOn}, 32'h0, "power in shutdown");
    pix(8'h05, 1'b0, 1'b0, 1'b0, ent[3], "after shutdown");
    $display("test display done");
  endtask

  task automatic test_power();
    host_u.xfer(1'b1, palette_pkg::OFS_CONTROL, 32'h3, rd, er);
    pix(8'h05, 1'b0, 1'b0, 1'b0, 18'h0, "powered down");
    chk({31'h0, converterPowerOn}, 32'h0, "power while down");
    host_u.xfer(1'b0, palette_pkg::OFS_STATUS, 32'h0, rd, er);
    chk({31'h0, rd[4]}, 32'h1, "power down status");
    host_u.load(8'h09, ent[0], 1'b1);
    host_u.xfer(1'b1, palette_pkg::OFS_READ_INDEX, 32'h09, rd, er);
    rde(ent[0], "table while down");
    host_u.xfer(1'b1, palette_pkg::OFS_CONTROL, 32'h4, rd, er);
    pix(8'h05, 1'b0, 1'b0, 1'b0, 18'h0, "panel only");
    chk({29'h0, converterPowerOn, hsyncOe, vsyncOe}, 32'h0, "panel only drive");
    host_u.xfer(1'b1, palette_pkg::OFS_CONTROL, 32'h0, rd, er);
    pix(8'h05, 1'b0, 1'b0, 1'b0, ent[3], "powered again");
    chk({29'h0, converterPowerOn, hsyncOe, vsyncOe}, 32'h7, "drive again");
    $display("test power done");
  endtask

  // ==========================================================================
  // Verdict
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    test_reset();
    test_table();
    test_restart();
    test_display();
    test_power();
    print_verdict();
  end

  // Whole run needs a few hundred cycles
  initial
  begin
    #200000;
    errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    print_verdict();
  end
endmodule

/* tb/palette_host_model.sv */
// APB host model that loads and reads the colour table
`timescale 1ns/10ps

// ==========================================================================
// Host model
module palette_host_model (
  input  wire logic        clock,
  output logic      [11:0] paddr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial
  begin
    paddr   = 12'h000;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    pwdata  = 32'h00000000;
  end

  // Called just after a rising edge; one idle cycle follows to keep strobes clean
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  // Index first when asked, then red, green, blue; a finished triple advances
  task automatic load(input logic [7:0] idx, input palette_pkg::rgb_s c, input logic setIdx);
    logic [31:0] q;
    logic        e;
    if (setIdx)
      xfer(1'b1, palette_pkg::OFS_WRITE_INDEX, {24'h0, idx}, q, e);
    xfer(1'b1, palette_pkg::OFS_COLOR_DATA, {26'h0, c.red}, q, e);
    xfer(1'b1, palette_pkg::OFS_COLOR_DATA, {26'h0, c.green}, q, e);
    xfer(1'b1, palette_pkg::OFS_COLOR_DATA, {26'h0, c.blue}, q, e);
  endtask
endmodule
